//--- shared/sro_pkg.sv
// constants for the stack, rotate and return execution unit
// assumes a 256-byte register file and an 8-bit flag register
////////////////////////////////////////////////////////////////////////////////
package sro_pkg;
  localparam logic [7:0] SRO_STACK_IDX_ADDR = 8'hD9;
  localparam logic [7:0] SRO_OP_PULL_DIR = 8'h50;
  localparam logic [7:0] SRO_OP_PULL_IND = 8'h51;
  localparam logic [7:0] SRO_OP_STORE_DIR = 8'h70;
  localparam logic [7:0] SRO_OP_STORE_IND = 8'h71;
  localparam logic [7:0] SRO_OP_CARRY_CLR = 8'hCF;
  localparam logic [7:0] SRO_OP_RETURN = 8'hAF;
  localparam logic [7:0] SRO_OP_ROT_CIRC_DIR = 8'h90;
  localparam logic [7:0] SRO_OP_ROT_CIRC_IND = 8'h91;
  localparam logic [7:0] SRO_OP_ROT_CARRY_DIR = 8'h10;
  localparam logic [7:0] SRO_OP_ROT_CARRY_IND = 8'h11;
  localparam logic [3:0] SRO_CYC_STACK = 4'h8;
  localparam logic [3:0] SRO_CYC_SHORT = 4'h4;
  localparam logic [3:0] SRO_CYC_RETURN = 4'h8;
  localparam logic [1:0] SRO_LEN_ONE = 2'h1;
  localparam logic [1:0] SRO_LEN_TWO = 2'h2;
  // flag bit positions
  localparam int SRO_FLAG_C = 7;
  localparam int SRO_FLAG_Z = 6;
  localparam int SRO_FLAG_S = 5;
  localparam int SRO_FLAG_V = 4;
  localparam logic [7:0] SRO_FLAGS_RST = 8'h00;
  localparam logic [7:0] SRO_STACK_IDX_RST = 8'h00;

  typedef enum logic [2:0] {
    SRO_IDLE,
    SRO_INDIR,
    SRO_OPER,
    SRO_RET_LO,
    SRO_WAIT
  } sro_state_e;
endpackage

//--- core/sro_exec.sv
// execution unit for stack pull/store, carry clear, return, left rotates
// assumes an owning core presents one opcode plus operand with a start
// pulse while busy_o is low; register file is held here as an array.
// fetch side is told via pc_load_o to continue at pc_o.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sro_exec
  import sro_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand_i,
  input wire logic reg_we_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] flags_o,
  output logic [7:0] stack_index_o,
  output logic [15:0] pc_o,
  output logic pc_load_o,
  output logic busy_o,
  output logic done_o,
  output logic [1:0] length_o,
  output logic illegal_o
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    sro_state_e st;
    logic [7:0] op;
    logic [7:0] addr;
    logic [7:0] hi;
    logic [3:0] cnt;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic [15:0] pc;
    logic pc_load;
    logic busy;
    logic done;
    logic [1:0] len;
    logic illegal;
  } sro_state_s;

  sro_state_s s_r;
  sro_state_s s_nxt;
  logic [7:0] rf_r [0:255];
  logic rf_we;
  logic [7:0] rf_wa;
  logic [7:0] rf_wd;

  function automatic logic is_known(input logic [7:0] op);
    return op == SRO_OP_PULL_DIR || op == SRO_OP_PULL_IND ||
      op == SRO_OP_STORE_DIR || op == SRO_OP_STORE_IND ||
      op == SRO_OP_CARRY_CLR || op == SRO_OP_RETURN ||
      op == SRO_OP_ROT_CIRC_DIR || op == SRO_OP_ROT_CIRC_IND ||
      op == SRO_OP_ROT_CARRY_DIR || op == SRO_OP_ROT_CARRY_IND;
  endfunction

  function automatic logic [3:0] cycles_of(input logic [7:0] op);
    case (op)
      SRO_OP_PULL_DIR, SRO_OP_PULL_IND,
      SRO_OP_STORE_DIR, SRO_OP_STORE_IND: return SRO_CYC_STACK;
      SRO_OP_RETURN: return SRO_CYC_RETURN;
      default: return SRO_CYC_SHORT;
    endcase
  endfunction

  // done must rise on the edge that closes the last cycle, and the taking
  // edge already used one count, so the counter starts two short
  function automatic logic [3:0] first_count(input logic [7:0] op);
    return cycles_of(op) - 4'h2;
  endfunction

  // rotate-through-carry feeds the old carry into bit 0
  function automatic logic thru_carry(input logic [7:0] op);
    return op == SRO_OP_ROT_CARRY_DIR || op == SRO_OP_ROT_CARRY_IND;
  endfunction

  // indirect forms spend one cycle reading the pointer register
  function automatic logic is_indirect(input logic [7:0] op);
    return op == SRO_OP_PULL_IND || op == SRO_OP_STORE_IND ||
      op == SRO_OP_ROT_CIRC_IND || op == SRO_OP_ROT_CARRY_IND;
  endfunction

  function automatic logic [1:0] length_of(input logic [7:0] op);
    case (op)
      SRO_OP_CARRY_CLR, SRO_OP_RETURN: return SRO_LEN_ONE;
      default: return SRO_LEN_TWO;
    endcase
  endfunction

  // only a return hands a new address to the fetch side
  function automatic logic ends_with_fetch(input logic [7:0] op);
    return op == SRO_OP_RETURN;
  endfunction

  // shared by both left rotates; only the bit fed into bit 0 differs
  function automatic logic [7:0] rotl(
    input logic [7:0] val,
    input logic fill
  );
    return {val[6:0], fill};
  endfunction

  // carry, zero, sign and overflow after either left rotate; the unused
  // flag bits pass through untouched
  function automatic logic [7:0] rot_flags(
    input logic [7:0] old_flags,
    input logic [7:0] val_in,
    input logic [7:0] val_out
  );
    logic [7:0] f;
    f = old_flags;
    f[SRO_FLAG_C] = val_in[7];
    f[SRO_FLAG_Z] = (val_out == 8'h00);
    f[SRO_FLAG_S] = val_out[7];
    f[SRO_FLAG_V] = val_out[7] ^ val_in[7];
    return f;
  endfunction

  // stack index arithmetic wraps inside the 256-byte file on purpose
  function automatic logic [7:0] idx_step(
    input logic [7:0] idx,
    input logic [7:0] delta
  );
    return idx + delta;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // the sequencer needs the pointer read, the operation and the index step
  // before the done edge; shorter counts would end late or underflow
  if (SRO_CYC_SHORT < 4'h3 || SRO_CYC_STACK < 4'h4 ||
    SRO_CYC_RETURN < 4'h3)
  begin : g_cyc_check
    $error("cycle counts too short for the sequencer");
  end

  // the four flag bits must not overlap or a rotate would lose one
  if (SRO_FLAG_C == SRO_FLAG_Z || SRO_FLAG_C == SRO_FLAG_S ||
    SRO_FLAG_C == SRO_FLAG_V || SRO_FLAG_Z == SRO_FLAG_S ||
    SRO_FLAG_Z == SRO_FLAG_V || SRO_FLAG_S == SRO_FLAG_V)
  begin : g_flag_check
    $error("flag positions overlap");
  end

  // the fetch side relies on one-byte and two-byte lengths being distinct
  if (SRO_LEN_ONE == 2'h0 || SRO_LEN_TWO <= SRO_LEN_ONE)
  begin : g_len_check
    $error("instruction lengths unusable");
  end

  // the stack index is just register D9, so software sees it directly
  logic [7:0] sidx;
  logic [7:0] sidx_up1;
  logic [7:0] sidx_up2;
  logic [7:0] sidx_dn1;
  assign sidx = rf_r[SRO_STACK_IDX_ADDR];
  assign sidx_up1 = idx_step(sidx, 8'h01);
  assign sidx_up2 = idx_step(sidx, 8'h02);
  assign sidx_dn1 = idx_step(sidx, 8'hFF);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] opnd;
  logic [7:0] rot;
  logic cin;
  always_comb
  begin
    opnd = rf_r[s_r.addr];
    cin = thru_carry(s_r.op) ? s_r.flags[SRO_FLAG_C] : opnd[7];
    rot = rotl(opnd, cin);
  end

  // cycle plan, counted in edges after the taking edge c0:
  //   c1  pointer read (indirect forms only)
  //   next operation: copy, index drop, flag update or high byte latch
  //   next stack step: index raise, stack write or pointer load
  //   then wait until the counter runs out; done and busy change on the
  //   edge that closes the last cycle, so the next start may ride on done
  // hazard: a software write in any cycle in which the core writes is lost,
  // whatever its address; the core always wins
  // limitation: the register file has no reset, so the stack index is
  // unknown until software writes it
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.pc_load = 1'b0;
    s_nxt.illegal = 1'b0;
    rf_we = 1'b0;
    rf_wa = 8'h00;
    rf_wd = 8'h00;
    // software register port; core writes below take precedence
    if (reg_we_i)
    begin
      rf_we = 1'b1;
      rf_wa = reg_addr_i;
      rf_wd = reg_wdata_i;
    end
    s_nxt.rdata = reg_re_i ? rf_r[reg_addr_i] : 8'h00;
    if (s_r.cnt != 4'h0)
    begin
      s_nxt.cnt = s_r.cnt - 4'h1;
    end
    case (s_r.st)
      SRO_IDLE:
      begin
        if (start_i)
        begin
          if (!is_known(opcode_i))
          begin
            s_nxt.illegal = 1'b1;
          end
          else
          begin
            s_nxt.op = opcode_i;
            s_nxt.addr = operand_i;
            s_nxt.busy = 1'b1;
            s_nxt.cnt = first_count(opcode_i);
            s_nxt.len = length_of(opcode_i);
            s_nxt.st = is_indirect(opcode_i) ? SRO_INDIR : SRO_OPER;
          end
        end
      end
      SRO_INDIR:
      begin
        s_nxt.addr = rf_r[s_r.addr];
        s_nxt.st = SRO_OPER;
      end
      SRO_OPER:
      begin
        s_nxt.st = SRO_WAIT;
        case (s_r.op)
          SRO_OP_PULL_DIR, SRO_OP_PULL_IND:
          begin
            // the index step is done a cycle later, after the copy lands
            rf_we = 1'b1;
            rf_wa = s_r.addr;
            rf_wd = rf_r[sidx];
            s_nxt.st = SRO_RET_LO;
          end
          SRO_OP_STORE_DIR, SRO_OP_STORE_IND:
          begin
            rf_we = 1'b1;
            rf_wa = SRO_STACK_IDX_ADDR;
            rf_wd = sidx_dn1;
            s_nxt.hi = opnd;
            s_nxt.st = SRO_RET_LO;
          end
          SRO_OP_CARRY_CLR:
          begin
            s_nxt.flags[SRO_FLAG_C] = 1'b0;
          end
          SRO_OP_RETURN:
          begin
            s_nxt.hi = rf_r[sidx];
            s_nxt.st = SRO_RET_LO;
          end
          default:
          begin
            rf_we = 1'b1;
            rf_wa = s_r.addr;
            rf_wd = rot;
            s_nxt.flags = rot_flags(s_r.flags, opnd, rot);
          end
        endcase
      end
      SRO_RET_LO:
      begin
        s_nxt.st = SRO_WAIT;
        rf_we = 1'b1;
        rf_wa = SRO_STACK_IDX_ADDR;
        case (s_r.op)
          SRO_OP_RETURN:
          begin
            s_nxt.pc = {s_r.hi, rf_r[sidx_up1]};
            rf_wd = sidx_up2;
          end
          SRO_OP_STORE_DIR, SRO_OP_STORE_IND:
          begin
            rf_wa = sidx;
            rf_wd = s_r.hi;
          end
          default:
          begin
            rf_wd = sidx_up1;
          end
        endcase
      end
      SRO_WAIT:
      begin
        if (s_r.cnt == 4'h0)
        begin
          s_nxt.st = SRO_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.pc_load = ends_with_fetch(s_r.op);
        end
      end
      default:
      begin
        s_nxt.st = SRO_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '{st: SRO_IDLE, flags: SRO_FLAGS_RST, default: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // no reset on the array: contents are software's, index comes up unknown
  always_ff @(posedge core_clk_i)
  begin
    if (rf_we)
    begin
      rf_r[rf_wa] <= rf_wd;
    end
  end

  assign reg_rdata_o = s_r.rdata;
  assign flags_o = s_r.flags;
  assign pc_o = s_r.pc;
  assign pc_load_o = s_r.pc_load;
  assign busy_o = s_r.busy;
  assign done_o = s_r.done;
  assign length_o = s_r.len;
  assign illegal_o = s_r.illegal;
  assign stack_index_o = sidx;
endmodule
`default_nettype wire

//--- bench/sro_exec_sva.sv
// timing and flag checks on the stack, rotate and return unit
// assumes it is bound into every sro_exec instance
`timescale 1ns/1ps
`default_nettype none
module sro_exec_sva
  import sro_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic pc_load_o,
  input wire logic [7:0] flags_o,
  input wire logic [1:0] length_o,
  input wire logic illegal_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic tk, rot, lng, ret, clr;
  assign tk = start_i && !busy_o;
  assign rot = tk && opcode_i inside {8'h90, 8'h91, 8'h10, 8'h11};
  assign lng = tk && opcode_i inside {8'h50, 8'h51, 8'h70, 8'h71};
  assign ret = tk && opcode_i == SRO_OP_RETURN;
  assign clr = tk && opcode_i == SRO_OP_CARRY_CLR;
  ////////////////////////////////////////////////////////////////////////////
  a_short_done: assert property ((rot || clr) |=> busy_o[*3] ##1
    (done_o && !busy_o)) else $error("short op timing wrong");
  a_stack_done: assert property (lng |-> ##8
    (done_o && length_o == SRO_LEN_TWO)) else $error("stack op timing wrong");
  a_ret_time: assert property (ret |-> ##8 (done_o && pc_load_o))
    else $error("return timing wrong");
  a_ret_flags: assert property (ret |-> ##8 flags_o == $past(flags_o, 8))
    else $error("return changed flags");
  a_pull_flags: assert property (lng |-> ##8
    flags_o == $past(flags_o, 8)) else $error("stack op changed flags");
  a_clr_carry: assert property (clr |-> ##4 (!flags_o[7] &&
    length_o == SRO_LEN_ONE && flags_o[6:0] == $past(flags_o[6:0], 4)))
    else $error("carry clear wrong");
  a_rot_ovf: assert property (rot |-> ##4
    flags_o[4] == (flags_o[7] ^ flags_o[5])) else $error("overflow wrong");
  a_zero_sign: assert property (rot |-> ##4 !(flags_o[6] && flags_o[5]))
    else $error("zero and sign both set");
  a_circ_zero: assert property (rot && opcode_i[7] |-> ##4
    !(flags_o[6] && flags_o[7])) else $error("zero with carry set");
  a_illegal_pulse: assert property (tk && !(rot || lng || ret || clr) |=>
    (illegal_o && !busy_o)) else $error("unknown opcode not flagged");
endmodule
bind sro_exec sro_exec_sva u_sva (.core_clk_i, .rst_n_i, .start_i,
  .opcode_i, .busy_o, .done_o, .pc_load_o, .flags_o, .length_o,
  .illegal_o);
`default_nettype wire

//--- bench/test_stack_rotate_return_ops.sv
// self-checking bench for the stack, rotate and return unit
// assumes a 50 MHz clock and the one-cycle register port
`timescale 1ns/1ps
`default_nettype none
module test_stack_rotate_return_ops;
  import sro_pkg::*;
  logic clk = 0, rst_n = 0, start = 0, we = 0, re = 0;
  logic [7:0] op = 8'h00, opd = 8'h00, addr = 8'h00, wd = 8'h00;
  logic [7:0] rdata, flags, sidx;
  logic [15:0] pc;
  logic pc_load, busy, done, illegal;
  logic [1:0] len;
  int num_errors = 0, checked = 0, cycles = 0;
  always #10 clk = ~clk;
  sro_exec DUT (.core_clk_i(clk), .rst_n_i(rst_n), .start_i(start),
    .opcode_i(op), .operand_i(opd), .reg_we_i(we), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_re_i(re), .reg_rdata_o(rdata), .flags_o(flags),
    .stack_index_o(sidx), .pc_o(pc), .pc_load_o(pc_load), .busy_o(busy),
    .done_o(done), .length_o(len), .illegal_o(illegal));
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // waits up to ten edges for done, so only a unit slower than that fails the done check
  task automatic run(input logic [7:0] o, input logic [7:0] d,
    input logic [1:0] l);
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    opd <= d;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk({7'h00, busy}, 8'h01);
    repeat (10)
      if (done !== 1'b1)
      begin
        @(posedge clk);
        #1;
      end
    chk({7'h00, done}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    chk({6'h00, len}, {6'h00, l});
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(SRO_STACK_IDX_ADDR, 8'hBB);
    wr(8'hBB, 8'h55);
    wr(8'hBC, 8'h66);
    run(SRO_OP_PULL_DIR, 8'h00, SRO_LEN_TWO);
    rd(8'h00, 8'h55);
    wr(8'h00, 8'h01);
    run(SRO_OP_PULL_IND, 8'h00, SRO_LEN_TWO);
    rd(8'h01, 8'h66);
    rd(SRO_STACK_IDX_ADDR, 8'hBD);
    chk(sidx, 8'hBD);
    chk(flags, 8'h00);
    wr(SRO_STACK_IDX_ADDR, 8'hC0);
    wr(8'h40, 8'h4F);
    wr(8'h4F, 8'hAA);
    run(SRO_OP_STORE_DIR, 8'h40, SRO_LEN_TWO);
    run(SRO_OP_STORE_IND, 8'h40, SRO_LEN_TWO);
    rd(8'hBF, 8'h4F);
    rd(8'hBE, 8'hAA);
    chk(sidx, 8'hBE);
    $display("test stack done");
    wr(8'h00, 8'hAA);
    run(SRO_OP_ROT_CIRC_DIR, 8'h00, SRO_LEN_TWO);
    rd(8'h00, 8'h55);
    chk(flags, 8'h90);
    run(SRO_OP_ROT_CARRY_DIR, 8'h00, SRO_LEN_TWO);
    rd(8'h00, 8'hAB);
    chk(flags, 8'h30);
    wr(8'h01, 8'h02);
    wr(8'h02, 8'h80);
    run(SRO_OP_ROT_CIRC_IND, 8'h01, SRO_LEN_TWO);
    rd(8'h02, 8'h01);
    chk(flags, 8'h90);
    run(SRO_OP_CARRY_CLR, 8'h00, SRO_LEN_ONE);
    chk(flags, 8'h10);
    wr(8'h01, 8'h03);
    wr(8'h03, 8'h00);
    run(SRO_OP_ROT_CARRY_IND, 8'h01, SRO_LEN_TWO);
    rd(8'h03, 8'h00);
    chk(flags, 8'h40);
    $display("test rotate done");
    wr(SRO_STACK_IDX_ADDR, 8'hBC);
    wr(8'hBC, 8'h10);
    wr(8'hBD, 8'h1A);
    run(SRO_OP_RETURN, 8'h00, SRO_LEN_ONE);
    chk({7'h00, pc_load}, 8'h01);
    chk(pc[15:8], 8'h10);
    chk(pc[7:0], 8'h1A);
    chk(sidx, 8'hBE);
    chk(flags, 8'h40);
    $display("test return done");
    @(posedge clk);
    start <= 1'b1;
    op <= 8'hFF;
    @(posedge clk);
    start <= 1'b0;
    #1 chk({7'h00, illegal}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    @(posedge clk);
    #1 chk({7'h00, illegal}, 8'h00);
    $display("test illegal done");
    give_verdict();
  end
endmodule
`default_nettype wire
